//--- rtl/icc_pkg.sv
// Shared constants for the interrupt-controller command register block
package icc_pkg;

  // Configuration offset of the command register (byte address)
  localparam logic [7:0]  ICC_CMD_OFFSET       = 8'h04;
  localparam int          ICC_CMD_WIDTH        = 16;

  // Reset value of the command register
  localparam logic [15:0] ICC_CMD_RESET        = 16'h0000;

  // Writable bits: error_message_enable, parity_check_enable,
  // master_request_enable and memory_decode_enable
  localparam logic [15:0] ICC_CMD_WMASK        = 16'h0146;

  // Field positions
  localparam int          ICC_ERR_MSG_EN_POS   = 8;
  localparam int          ICC_WAIT_CYC_POS     = 7;
  localparam int          ICC_PAR_CHK_EN_POS   = 6;
  localparam int          ICC_PALETTE_POS      = 5;
  localparam int          ICC_WR_INVAL_POS     = 4;
  localparam int          ICC_SPEC_CYC_POS     = 3;
  localparam int          ICC_MST_REQ_EN_POS   = 2;
  localparam int          ICC_MEM_DEC_EN_POS   = 1;
  localparam int          ICC_IO_DEC_EN_POS    = 0;

  // Cycles from a taken read to its data
  localparam int          ICC_RD_LATENCY       = 1;

endpackage : icc_pkg

//--- rtl/icc_evt_gate.sv
// Registered one-cycle event pulse gated by an enable level
module icc_evt_gate
  import icc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic evt,
  input  wire logic enable,
  output logic      pulse_r
);

  typedef struct packed {
    logic pulse;
  } icc_gate_state_t;

  icc_gate_state_t st_r;
  icc_gate_state_t st_nxt;

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.pulse = evt & enable;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pulse_r = st_r.pulse;

endmodule // icc_evt_gate

//--- rtl/icc_cmd_reg.sv
// Command register of the interrupt-controller function and the gating it drives
// Functional notes
// - 16-bit register, resets zero, 15:9 read zero
// - Error message enable gates fatal/non-fatal messages
// - Capability error status updates regardless of enable
// - Wait cycle control reads zero, no effect
// - Parity check enable gates write parity reporting
// - Bits 5:3 hardwired zero, read-only
// - Master request enable gates upstream memory requests
// - Completions always returned, whatever master enable
// - Only memory and I/O requests are gated
// - Memory decode off master-aborts window requests
// - I/O decode reads zero, I/O never decoded
module icc_cmd_reg
  import icc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Configuration access port
  input  wire logic        cfg_wr_en,
  input  wire logic        cfg_rd_en,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [1:0]  cfg_be,
  input  wire logic [15:0] cfg_wdata,
  output logic [15:0]      cfg_rdata,
  output logic             cfg_rdata_valid,
  output logic             cfg_hit,
  output logic [15:0]      cmd_value,
  // Data parity error seen on a received write to this function
  input  wire logic        wr_parity_err,
  input  wire logic        wr_parity_fatal,
  output logic             par_detected,
  output logic             par_reported,
  output logic             cap_err_status_set,
  output logic             err_msg_fatal,
  output logic             err_msg_nonfatal,
  // Upstream requests originated by the interrupt forwarder
  input  wire logic        mst_in_valid,
  input  wire logic        mst_in_is_memio,
  output logic             mst_in_ready,
  output logic             mst_out_valid,
  input  wire logic        mst_out_ready,
  // Completions for received requests
  input  wire logic        cpl_in_valid,
  output logic             cpl_in_ready,
  output logic             cpl_out_valid,
  input  wire logic        cpl_out_ready,
  // Received target requests
  input  wire logic        tgt_req_valid,
  input  wire logic        tgt_req_is_mem,
  input  wire logic        tgt_win_hit,
  output logic             tgt_accept,
  output logic             tgt_master_abort
);

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] rdata;
    logic        rvalid;
    logic        hit;
    logic        par_det;
    logic        cap_set;
    logic        accept;
    logic        abort;
  } icc_state_t;

  icc_state_t st_r;
  icc_state_t st_nxt;

  logic        sel;
  logic [15:0] wr_merge;
  logic        err_msg_en;
  logic        par_chk_en;
  logic        mst_en;
  logic        mem_dec_en;
  logic        par_gated;
  logic        mst_pass;

  assign sel        = (cfg_addr == ICC_CMD_OFFSET);
  assign err_msg_en = st_r.cmd[ICC_ERR_MSG_EN_POS];
  assign par_chk_en = st_r.cmd[ICC_PAR_CHK_EN_POS];
  assign mst_en     = st_r.cmd[ICC_MST_REQ_EN_POS];
  assign mem_dec_en = st_r.cmd[ICC_MEM_DEC_EN_POS];

  // Byte enables pick lanes; the mask keeps every read-only bit at zero
  always_comb
  begin
    wr_merge = st_r.cmd;
    if (cfg_be[0])
    begin
      wr_merge[7:0] = cfg_wdata[7:0];
    end
    if (cfg_be[1])
    begin
      wr_merge[15:8] = cfg_wdata[15:8];
    end
    wr_merge = wr_merge & ICC_CMD_WMASK;
  end

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = cfg_rd_en;
    st_nxt.hit    = (cfg_rd_en | cfg_wr_en) & sel;
    st_nxt.rdata  = 16'h0000;
    if (cfg_rd_en && sel)
    begin
      st_nxt.rdata = st_r.cmd & ICC_CMD_WMASK;
    end
    // A write in the same cycle as a read returns the old value
    if (cfg_wr_en && sel)
    begin
      st_nxt.cmd = wr_merge;
    end
    // Detection and capability status never depend on the enables
    st_nxt.par_det = wr_parity_err;
    st_nxt.cap_set = wr_parity_err;
    // I/O requests that hit the window always fall through to master abort: no I/O decode
    st_nxt.accept  = tgt_req_valid & tgt_win_hit & tgt_req_is_mem & mem_dec_en;
    st_nxt.abort   = tgt_req_valid & tgt_win_hit
                     & (~tgt_req_is_mem | ~mem_dec_en);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      st_r     <= '0;
      st_r.cmd <= ICC_CMD_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Error messages need both parity checking and error message enable
  assign par_gated = wr_parity_err & par_chk_en;

  icc_evt_gate u_par_rep (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .evt     (wr_parity_err),
    .enable  (par_chk_en),
    .pulse_r (par_reported)
  );

  icc_evt_gate u_err_fatal (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .evt     (par_gated & wr_parity_fatal),
    .enable  (err_msg_en),
    .pulse_r (err_msg_fatal)
  );

  icc_evt_gate u_err_nonfatal (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .evt     (par_gated & ~wr_parity_fatal),
    .enable  (err_msg_en),
    .pulse_r (err_msg_nonfatal)
  );

  // Blocked memory/I/O requests stall rather than drop, so a pending
  // interrupt goes out once software enables mastering
  assign mst_pass      = mst_en | ~mst_in_is_memio;
  assign mst_out_valid = mst_in_valid & mst_pass;
  assign mst_in_ready  = mst_out_ready & mst_pass;

  assign cpl_out_valid = cpl_in_valid;
  assign cpl_in_ready  = cpl_out_ready;

  assign cfg_rdata          = st_r.rdata;
  assign cfg_rdata_valid    = st_r.rvalid;
  assign cfg_hit            = st_r.hit;
  assign cmd_value          = st_r.cmd;
  assign par_detected       = st_r.par_det;
  assign cap_err_status_set = st_r.cap_set;
  assign tgt_accept         = st_r.accept;
  assign tgt_master_abort   = st_r.abort;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_ro_bits_zero;
    (cmd_value & ~ICC_CMD_WMASK) == 16'h0000;
  endproperty
  a_ro_bits_zero: assert property (p_ro_bits_zero)
    else $error("read-only command bits not zero");

  property p_read_value;
    cfg_rd_en && sel |=> cfg_rdata_valid && cfg_rdata == $past(cmd_value) && cfg_hit;
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("command read returned wrong data");

  property p_write_update;
    cfg_wr_en && sel && cfg_be == 2'b11
      |=> cmd_value == ($past(cfg_wdata) & ICC_CMD_WMASK);
  endproperty
  a_write_update: assert property (p_write_update)
    else $error("command write not applied through mask");

  property p_hold_no_write;
    nrst && !(cfg_wr_en && sel) |=> $stable(cmd_value);
  endproperty
  a_hold_no_write: assert property (p_hold_no_write)
    else $error("command changed without a write");

  property p_err_msg_gate;
    wr_parity_err && !err_msg_en |=> !err_msg_fatal && !err_msg_nonfatal;
  endproperty
  a_err_msg_gate: assert property (p_err_msg_gate)
    else $error("error message sent while disabled");

  property p_err_msg_sent;
    wr_parity_err && err_msg_en && par_chk_en
      |=> (err_msg_fatal == $past(wr_parity_fatal)) && (err_msg_nonfatal != err_msg_fatal);
  endproperty
  a_err_msg_sent: assert property (p_err_msg_sent)
    else $error("enabled parity error sent no message");

  property p_cap_status;
    wr_parity_err |=> cap_err_status_set && par_detected;
  endproperty
  a_cap_status: assert property (p_cap_status)
    else $error("capability status missed a parity error");

  property p_par_report;
    wr_parity_err |=> par_reported == $past(par_chk_en);
  endproperty
  a_par_report: assert property (p_par_report)
    else $error("parity report does not follow enable");

  property p_mst_block;
    !mst_en && mst_in_is_memio |-> !mst_out_valid && !mst_in_ready;
  endproperty
  a_mst_block: assert property (p_mst_block)
    else $error("memory request issued with mastering off");

  property p_other_pass;
    !mst_in_is_memio && mst_in_valid |-> mst_out_valid;
  endproperty
  a_other_pass: assert property (p_other_pass)
    else $error("non memory request blocked");

  property p_cpl_pass;
    cpl_in_valid |-> cpl_out_valid;
  endproperty
  a_cpl_pass: assert property (p_cpl_pass)
    else $error("completion blocked");

  property p_mem_abort;
    tgt_req_valid && tgt_win_hit && tgt_req_is_mem && !mem_dec_en
      |=> tgt_master_abort && !tgt_accept;
  endproperty
  a_mem_abort: assert property (p_mem_abort)
    else $error("disabled memory window not aborted");

  property p_io_abort;
    tgt_req_valid && tgt_win_hit && !tgt_req_is_mem |=> tgt_master_abort;
  endproperty
  a_io_abort: assert property (p_io_abort)
    else $error("I/O request was decoded");

  property p_wait_cyc_zero;
    cmd_value[ICC_WAIT_CYC_POS] == 1'b0;
  endproperty
  a_wait_cyc_zero: assert property (p_wait_cyc_zero)
    else $error("wait cycle control bit not zero");

  property p_legacy_bits_zero;
    !cmd_value[ICC_PALETTE_POS] && !cmd_value[ICC_WR_INVAL_POS] && !cmd_value[ICC_SPEC_CYC_POS];
  endproperty
  a_legacy_bits_zero: assert property (p_legacy_bits_zero)
    else $error("hardwired command bit not zero");

  property p_io_dec_zero;
    cmd_value[ICC_IO_DEC_EN_POS] == 1'b0;
  endproperty
  a_io_dec_zero: assert property (p_io_dec_zero)
    else $error("I/O decode bit not zero");

  property p_mem_accept;
    tgt_req_valid && tgt_win_hit && tgt_req_is_mem && mem_dec_en
      |=> tgt_accept && !tgt_master_abort;
  endproperty
  a_mem_accept: assert property (p_mem_accept)
    else $error("enabled memory window request not accepted");

  // Without an error event nothing may be reported or signalled
  property p_par_quiet;
    !wr_parity_err |=> !par_detected && !par_reported && !err_msg_fatal && !err_msg_nonfatal;
  endproperty
  a_par_quiet: assert property (p_par_quiet)
    else $error("parity event shown without an error");

  property p_cpl_ready;
    cpl_in_ready == cpl_out_ready;
  endproperty
  a_cpl_ready: assert property (p_cpl_ready)
    else $error("completion backpressure not passed through");

  c_mem_accept: cover property (tgt_accept);
  c_err_fatal:  cover property (err_msg_fatal);
  c_mst_stall:  cover property (mst_in_valid && !mst_in_ready ##1 mst_in_ready);
  c_write_read: cover property (cfg_wr_en && sel ##1 cfg_rd_en && sel);
  c_mem_abort:  cover property (tgt_master_abort);

endmodule // icc_cmd_reg

//--- verification/icc_rc_model.sv
// Upstream link partner that takes requests promptly or stalls on alternate cycles
module icc_rc_model
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic slow,
  output logic      mst_out_ready,
  output logic      cpl_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic stall_r;

  always_ff @(posedge sys_clk)
    stall_r <= nrst ? (slow & ~stall_r) : 1'b0;

  // Credits run out on both paths alike, so completions are stalled too
  assign mst_out_ready = ~stall_r;
  assign cpl_out_ready = ~stall_r;
endmodule // icc_rc_model

//--- verification/intr_ctrl_pci_command_reg_bench.sv
// Self-checking bench for the interrupt-controller command register
module intr_ctrl_pci_command_reg_bench
  import icc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0, nrst = 1'b0, slow = 1'b0;
  logic        cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, wr_parity_err = 1'b0;
  logic        wr_parity_fatal = 1'b0, mst_in_valid = 1'b0, mst_in_is_memio = 1'b0;
  logic        cpl_in_valid = 1'b0, tgt_req_valid = 1'b0, tgt_req_is_mem = 1'b0;
  logic        tgt_win_hit = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [1:0]  cfg_be = 2'h0;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, cmd_value;
  logic        cfg_rdata_valid, cfg_hit, par_detected, par_reported, cap_err_status_set;
  logic        err_msg_fatal, err_msg_nonfatal, mst_in_ready, mst_out_valid;
  logic        mst_out_ready, cpl_in_ready, cpl_out_valid, cpl_out_ready;
  logic        tgt_accept, tgt_master_abort;
  int          num_errors = 0, samples_checked = 0;

  always #2 sys_clk = ~sys_clk;

  icc_cmd_reg dut (.sys_clk(sys_clk), .nrst(nrst), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid), .cfg_hit(cfg_hit),
    .cmd_value(cmd_value), .wr_parity_err(wr_parity_err), .wr_parity_fatal(wr_parity_fatal),
    .par_detected(par_detected), .par_reported(par_reported),
    .cap_err_status_set(cap_err_status_set), .err_msg_fatal(err_msg_fatal),
    .err_msg_nonfatal(err_msg_nonfatal), .mst_in_valid(mst_in_valid),
    .mst_in_is_memio(mst_in_is_memio), .mst_in_ready(mst_in_ready),
    .mst_out_valid(mst_out_valid), .mst_out_ready(mst_out_ready),
    .cpl_in_valid(cpl_in_valid), .cpl_in_ready(cpl_in_ready), .cpl_out_valid(cpl_out_valid),
    .cpl_out_ready(cpl_out_ready), .tgt_req_valid(tgt_req_valid),
    .tgt_req_is_mem(tgt_req_is_mem), .tgt_win_hit(tgt_win_hit), .tgt_accept(tgt_accept),
    .tgt_master_abort(tgt_master_abort));

  icc_rc_model rc (.sys_clk(sys_clk), .nrst(nrst), .slow(slow),
    .mst_out_ready(mst_out_ready), .cpl_out_ready(cpl_out_ready));

  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cb(string what, logic got, logic exp);
    chk(what, {15'h0, got}, {15'h0, exp});
  endtask

  // Each access ends one edge after its strobe, with the registered answer standing
  task automatic acc(logic wr, logic [7:0] a, logic [1:0] be, logic [15:0] d);
    @(posedge sys_clk);
    cfg_wr_en <= wr;
    cfg_rd_en <= ~wr;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
    cfg_rd_en <= 1'b0;
    #1;
  endtask

  task automatic pulse(logic fatal, logic tgt);
    @(posedge sys_clk);
    wr_parity_err <= ~tgt;
    wr_parity_fatal <= fatal;
    tgt_req_valid <= tgt;
    @(posedge sys_clk);
    wr_parity_err <= 1'b0;
    tgt_req_valid <= 1'b0;
    #1;
  endtask

  task automatic mst(logic memio);
    @(posedge sys_clk);
    mst_in_valid <= 1'b1;
    mst_in_is_memio <= memio;
    cpl_in_valid <= 1'b1;
    #1;
  endtask

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    acc(1'b0, ICC_CMD_OFFSET, 2'h0, 16'h0000);
    chk("reset", cfg_rdata, ICC_CMD_RESET);
    cb("hit", cfg_hit, 1'b1);
    cb("rvalid", cfg_rdata_valid, 1'b1);
    mst(1'b1);
    cb("mst blocked", mst_out_valid | mst_in_ready, 1'b0);
    cb("cpl", cpl_out_valid, 1'b1);
    mst(1'b0);
    cb("non memio", mst_out_valid, 1'b1);
    @(posedge sys_clk);
    mst_in_valid <= 1'b0;
    cpl_in_valid <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, ICC_CMD_OFFSET, 2'h3, {7'h00, i[1], 1'b0, i[0], 6'h00});
      for (int f = 0; f < 2; f++)
      begin
        pulse(f[0], 1'b0);
        cb("detected", par_detected & cap_err_status_set, 1'b1);
        cb("reported", par_reported, i[0]);
        cb("fatal", err_msg_fatal, i[0] & i[1] & f[0]);
        cb("nonfatal", err_msg_nonfatal, i[0] & i[1] & ~f[0]);
      end
    end
    acc(1'b1, ICC_CMD_OFFSET, 2'h3, 16'hffff);
    chk("cmd", cmd_value, ICC_CMD_WMASK);
    cb("no rvalid", cfg_rdata_valid, 1'b0);
    acc(1'b0, ICC_CMD_OFFSET, 2'h0, 16'h0000);
    chk("readback", cfg_rdata, 16'h0146);
    acc(1'b1, ICC_CMD_OFFSET, 2'h1, 16'h0000);
    acc(1'b0, ICC_CMD_OFFSET, 2'h0, 16'h0000);
    chk("lane", cfg_rdata, 16'h0100);
    acc(1'b1, 8'h08, 2'h3, 16'hffff);
    acc(1'b0, 8'h08, 2'h0, 16'h0000);
    chk("unmapped", {cfg_rdata[15:1], cfg_hit}, 16'h0000);
    chk("kept", cmd_value, 16'h0100);
    @(posedge sys_clk);
    slow <= 1'b1;
    acc(1'b1, ICC_CMD_OFFSET, 2'h3, 16'h0004);
    @(posedge sys_clk);
    tgt_win_hit <= 1'b1;
    tgt_req_is_mem <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      mst(1'b1);
      cb("mst valid", mst_out_valid, 1'b1);
      cb("mst ready", mst_in_ready, mst_out_ready);
      cb("cpl ready", cpl_in_ready, cpl_out_ready);
    end
    @(posedge sys_clk);
    mst_in_valid <= 1'b0;
    cpl_in_valid <= 1'b0;
    pulse(1'b0, 1'b1);
    cb("abort", tgt_master_abort & ~tgt_accept, 1'b1);
    acc(1'b1, ICC_CMD_OFFSET, 2'h3, 16'h0002);
    pulse(1'b0, 1'b1);
    cb("accept", tgt_accept & ~tgt_master_abort, 1'b1);
    @(posedge sys_clk);
    tgt_req_is_mem <= 1'b0;
    pulse(1'b0, 1'b1);
    cb("io abort", tgt_master_abort & ~tgt_accept, 1'b1);
    // Mid-run reset must clear what software wrote
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    acc(1'b0, ICC_CMD_OFFSET, 2'h0, 16'h0000);
    chk("reset again", cfg_rdata, ICC_CMD_RESET);
    wrap_up();
  end
endmodule // intr_ctrl_pci_command_reg_bench
